// ===== hdl/psd_pkg.sv
// psd_pkg: opcode tables, decode record and state encoding for the
// second-page opcode decoder.
// assumes: one core clock; bytes arrive from logic on that same clock.
package psd_pkg;

    // prefix that opens the second opcode page
    localparam logic [7:0] PAGE2_PREFIX = 8'h9e;

    // high nibble of the opcode selects the column group
    localparam logic [3:0] ROW_RMW  = 4'h6;  // read-modify-write, short stack offset
    localparam logic [3:0] ROW_STK16 = 4'hd; // register/memory, long stack offset
    localparam logic [3:0] ROW_STK8  = 4'he; // register/memory, short stack offset
    localparam logic [3:0] ROW_WORD = 4'hf;  // 16-bit index pair, short stack offset

    // single opcodes outside the table groups
    localparam logic [7:0] OPC_PLD_NOF  = 8'hae;
    localparam logic [7:0] OPC_PLD_OF16 = 8'hbe;
    localparam logic [7:0] OPC_PLD_OF8  = 8'hce;
    localparam logic [7:0] OPC_PCMP_STK = 8'hf3;
    localparam logic [7:0] OPC_PLD_STK  = 8'hfe;
    localparam logic [7:0] OPC_PST_STK  = 8'hff;

    // instruction lengths in bytes, prefix included
    localparam logic [2:0] LEN_MIN   = 3'd2;
    localparam logic [2:0] LEN_SHORT = 3'd3;
    localparam logic [2:0] LEN_LONG  = 3'd4;

    // bus-cycle counts
    localparam logic [3:0] CYC_RMW     = 4'd6;
    localparam logic [3:0] CYC_TEST     = 4'd5;
    localparam logic [3:0] CYC_DECBR    = 4'd8;
    localparam logic [3:0] CYC_STK16    = 4'd5;
    localparam logic [3:0] CYC_STK8     = 4'd4;
    localparam logic [3:0] CYC_PCMP     = 4'd6;
    localparam logic [3:0] CYC_PLD_STK  = 4'd5;
    localparam logic [3:0] CYC_PST_STK  = 4'd5;
    localparam logic [3:0] CYC_PLD_NOF  = 4'd5;
    localparam logic [3:0] CYC_PLD_OF16 = 4'd6;
    localparam logic [3:0] CYC_PLD_OF8  = 4'd5;

    // operand byte counting
    localparam logic [2:0] OPERAND_STEP = 3'd1;
    localparam logic [1:0] OFS_NONE     = 2'd0;
    localparam logic [1:0] OFS_SHORT    = 2'd1;
    localparam logic [1:0] OFS_LONG     = 2'd2;
    localparam logic [15:0] OFS_CLEAR   = 16'h0000;

    typedef enum logic [4:0] {
        op_none, op_negate_operand, op_compare_branch_equal, op_complement,
        op_shift_right, op_rotate_right, op_arith_shift_right, op_shift_left,
        op_rotate_left, op_decrement, op_decrement_branch_nonzero, op_increment,
        op_test_operand, op_clear, op_subtract, op_compare, op_subtract_carry,
        op_index_compare, op_and, op_bit_test, op_load_acc, op_store_acc, op_xor,
        op_add_carry, op_or, op_add, op_load_index, op_store_index,
        op_index_pair_compare, op_index_pair_load, op_index_pair_store
    } psd_op_t;

    typedef enum logic [2:0] {
        mode_none, stack_offset8_mode, stack_offset16_mode,
        indexed_no_offset_mode, indexed_offset8_mode, indexed_offset16_mode
    } psd_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_PREFIX  = 2'b01,
        ST_OPERAND = 2'b11
    } psd_state_t;

    // one decoded entry as handed to fetch and sequencing
    typedef struct packed {
        psd_op_t   op;
        psd_mode_t mode;
        logic [2:0] len;
        logic [3:0] cycles;
        logic       illegal;
    } psd_dec_t;

    // operations by low nibble; op_none marks a hole
    localparam psd_op_t RMW_OPS [16] = '{
        op_negate_operand, op_compare_branch_equal, op_none, op_complement,
        op_shift_right, op_none, op_rotate_right, op_arith_shift_right,
        op_shift_left, op_rotate_left, op_decrement, op_decrement_branch_nonzero,
        op_increment, op_test_operand, op_none, op_clear};
    localparam psd_op_t REG_OPS [16] = '{
        op_subtract, op_compare, op_subtract_carry, op_index_compare,
        op_and, op_bit_test, op_load_acc, op_store_acc,
        op_xor, op_add_carry, op_or, op_add,
        op_none, op_none, op_load_index, op_store_index};

endpackage

// ===== hdl/psd_decoder.sv
// psd_decoder: decodes prefixed second-page opcodes, walks their operand
// bytes and forms the stack-relative effective address.
// assumes: the fetch unit shares i_clk_sys and i_rst_n and offers one
// instruction byte per i_byte_valid, in program order.
`timescale 1ns/10ps

// Behaviour
// - after the page-two prefix, the next byte decodes against page two
// - 9E60 is stack-short negate, three bytes, six cycles
// - 9E61 is stack-short compare-branch-equal, four bytes, six cycles
// - 9E6B is stack-short decrement-branch-nonzero, four bytes, eight cycles
// - 9E6D is stack-short test, three bytes, five cycles
// - other 9E6x read-modify-write ops: stack-short, three bytes, six cycles
// - 9EDx register/memory ops: stack-long, four bytes, five cycles
// - 9EEx register/memory ops: stack-short, three bytes, four cycles
// - 9EF3 is index pair compare, stack-short, three bytes, six cycles
// - 9EFE is index pair load, stack-short, three bytes, five cycles
// - 9EAE is index pair load, indexed no offset, two bytes, five cycles
// - 9EBE is index pair load, indexed long offset, four bytes, six cycles
// - 9ECE is index pair load, indexed short offset, three bytes, five cycles
// - stack address is stack pointer plus one or two offset bytes
// - each entry gives operation, mode, byte count and cycle count
module psd_decoder
    import psd_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // byte stream from fetch, and the stack pointer
    input  wire logic        i_byte_valid,
    input  wire logic [7:0]  i_byte,
    input  wire logic [15:0] i_sp,
    // decode result
    output psd_dec_t         o_dec,
    output logic             o_dec_valid,
    // stack-relative effective address and page-two activity flag
    output logic [15:0]      o_ea,
    output logic             o_ea_valid,
    output logic             o_page2_active
);

    // decode one second-page opcode byte into its entry
    function automatic psd_dec_t psd_decode(input logic [7:0] opc);
        psd_dec_t d;
        d = '{op: op_none, mode: mode_none, len: LEN_MIN, cycles: '0, illegal: 1'b1};
        if (opc[7:4] == ROW_RMW) begin
            d.op     = RMW_OPS[opc[3:0]];
            d.mode   = stack_offset8_mode;
            d.len    = LEN_SHORT;
            d.cycles = CYC_RMW;
            if (d.op == op_compare_branch_equal) begin
                d.len = LEN_LONG;
            end else if (d.op == op_decrement_branch_nonzero) begin
                d.len    = LEN_LONG;
                d.cycles = CYC_DECBR;
            end else if (d.op == op_test_operand) begin
                d.cycles = CYC_TEST;
            end
        end else if (opc[7:4] == ROW_STK16) begin
            d.op     = REG_OPS[opc[3:0]];
            d.mode   = stack_offset16_mode;
            d.len    = LEN_LONG;
            d.cycles = CYC_STK16;
        end else if (opc[7:4] == ROW_STK8) begin
            d.op     = REG_OPS[opc[3:0]];
            d.mode   = stack_offset8_mode;
            d.len    = LEN_SHORT;
            d.cycles = CYC_STK8;
        end else if (opc == OPC_PCMP_STK) begin
            d = '{op_index_pair_compare, stack_offset8_mode, LEN_SHORT, CYC_PCMP, 1'b0};
        end else if (opc == OPC_PLD_STK) begin
            d = '{op_index_pair_load, stack_offset8_mode, LEN_SHORT, CYC_PLD_STK, 1'b0};
        end else if (opc == OPC_PST_STK) begin
            d = '{op_index_pair_store, stack_offset8_mode, LEN_SHORT, CYC_PST_STK, 1'b0};
        end else if (opc == OPC_PLD_NOF) begin
            d = '{op_index_pair_load, indexed_no_offset_mode, LEN_MIN, CYC_PLD_NOF, 1'b0};
        end else if (opc == OPC_PLD_OF16) begin
            d = '{op_index_pair_load, indexed_offset16_mode, LEN_LONG, CYC_PLD_OF16, 1'b0};
        end else if (opc == OPC_PLD_OF8) begin
            d = '{op_index_pair_load, indexed_offset8_mode, LEN_SHORT, CYC_PLD_OF8, 1'b0};
        end
        // holes in the table groups fall back to the illegal entry
        if (d.op == op_none) begin
            d = '{op: op_none, mode: mode_none, len: LEN_MIN, cycles: '0, illegal: 1'b1};
        end else begin
            d.illegal = 1'b0;
        end
        return d;
    endfunction

    // offset bytes that follow the opcode for a mode
    function automatic logic [1:0] psd_ofs_bytes(input psd_mode_t m);
        logic [1:0] n;
        n = OFS_NONE;
        if (m == stack_offset8_mode || m == indexed_offset8_mode) begin
            n = OFS_SHORT;
        end else if (m == stack_offset16_mode || m == indexed_offset16_mode) begin
            n = OFS_LONG;
        end
        return n;
    endfunction

    psd_state_t state;
    psd_state_t next_state;
    psd_dec_t   dec_now;
    psd_mode_t  mode_q;
    logic [2:0]  remain;
    logic [1:0]  ofs_left;
    logic [15:0] ofs;
    logic [15:0] next_ofs;
    logic        take_opc;
    logic        take_opr;
    logic        last_opr;

    assign dec_now  = psd_decode(i_byte);
    assign take_opc = (state == ST_PREFIX) && i_byte_valid;
    assign take_opr = (state == ST_OPERAND) && i_byte_valid;
    assign last_opr = take_opr && (remain == OPERAND_STEP);
    // offset bytes arrive high byte first, so shifting left builds the word
    assign next_ofs = (ofs_left != OFS_NONE) ? {ofs[7:0], i_byte} : ofs;

    // sequencing: prefix, opcode, then operand bytes until the length is used
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (i_byte_valid && i_byte == PAGE2_PREFIX) begin
                    next_state = ST_PREFIX;
                end
            end
            ST_PREFIX: begin
                if (i_byte_valid) begin
                    next_state = (dec_now.len == LEN_MIN) ? ST_IDLE : ST_OPERAND;
                end
            end
            ST_OPERAND: begin
                if (last_opr) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state          <= ST_IDLE;
            o_page2_active <= 1'b0;
        end else begin
            state          <= next_state;
            o_page2_active <= (next_state != ST_IDLE);
        end
    end

    // operand counting; operand bytes are skipped so a 9E offset byte is
    // never mistaken for a fresh prefix
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            remain   <= '0;
            ofs_left <= OFS_NONE;
            ofs      <= OFS_CLEAR;
            mode_q   <= mode_none;
        end else if (take_opc) begin
            remain   <= dec_now.len - LEN_MIN;
            ofs_left <= psd_ofs_bytes(dec_now.mode);
            ofs      <= OFS_CLEAR;
            mode_q   <= dec_now.mode;
        end else if (take_opr) begin
            remain <= remain - OPERAND_STEP;
            ofs    <= next_ofs;
            if (ofs_left != OFS_NONE) begin
                ofs_left <= ofs_left - OFS_SHORT;
            end
        end
    end

    // decoded entry, presented once per opcode byte
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dec       <= '{op: op_none, mode: mode_none, len: '0, cycles: '0, illegal: 1'b0};
            o_dec_valid <= 1'b0;
        end else begin
            o_dec_valid <= take_opc;
            if (take_opc) begin
                o_dec <= dec_now;
            end
        end
    end

    // effective address: stack pointer sampled with the last operand byte;
    // indexed forms need the index pair, which lives in the datapath
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ea       <= '0;
            o_ea_valid <= 1'b0;
        end else begin
            o_ea_valid <= last_opr &&
                          (mode_q == stack_offset8_mode || mode_q == stack_offset16_mode);
            if (last_opr) begin
                o_ea <= i_sp + next_ofs;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    prefix_entry_a: assert property (
        state == ST_IDLE && i_byte_valid && i_byte == PAGE2_PREFIX |=> o_page2_active
        ##0 state == ST_PREFIX) else $error("prefix not taken");
    negate_decode_a: assert property (
        take_opc && i_byte == 8'h60 |=> o_dec_valid && o_dec.op == op_negate_operand
        && o_dec.len == LEN_SHORT && o_dec.cycles == CYC_RMW) else $error("negate entry");
    cmp_branch_a: assert property (
        take_opc && i_byte == 8'h61 |=> o_dec.op == op_compare_branch_equal
        && o_dec.len == LEN_LONG && o_dec.cycles == CYC_RMW) else $error("cmp branch entry");
    dec_branch_a: assert property (
        take_opc && i_byte == 8'h6b |=> o_dec.op == op_decrement_branch_nonzero
        && o_dec.len == LEN_LONG && o_dec.cycles == CYC_DECBR) else $error("dec branch entry");
    test_decode_a: assert property (
        take_opc && i_byte == 8'h6d |=> o_dec.op == op_test_operand
        && o_dec.len == LEN_SHORT && o_dec.cycles == CYC_TEST) else $error("test entry");
    rmw_group_a: assert property (
        take_opc && i_byte inside {8'h63, 8'h64, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a,
        8'h6c, 8'h6f} |=> !o_dec.illegal && o_dec.mode == stack_offset8_mode
        && o_dec.len == LEN_SHORT && o_dec.cycles == CYC_RMW) else $error("rmw entry");
    long_stack_a: assert property (
        take_opc && i_byte[7:4] == ROW_STK16 && !dec_now.illegal
        |=> o_dec.mode == stack_offset16_mode && o_dec.len == LEN_LONG
        && o_dec.cycles == CYC_STK16) else $error("long stack entry");
    short_stack_a: assert property (
        take_opc && i_byte[7:4] == ROW_STK8 && !dec_now.illegal
        |=> o_dec.mode == stack_offset8_mode && o_dec.len == LEN_SHORT
        && o_dec.cycles == CYC_STK8) else $error("short stack entry");
    pair_compare_a: assert property (
        take_opc && i_byte == 8'hf3 |=> o_dec.op == op_index_pair_compare
        && o_dec.len == LEN_SHORT && o_dec.cycles == CYC_PCMP) else $error("pair compare");
    pair_load_sp_a: assert property (
        take_opc && i_byte == 8'hfe |=> o_dec.op == op_index_pair_load
        && o_dec.mode == stack_offset8_mode && o_dec.cycles == CYC_PLD_STK)
        else $error("pair load stack");
    pair_load_nof_a: assert property (
        take_opc && i_byte == 8'hae |=> o_dec.mode == indexed_no_offset_mode
        && o_dec.len == LEN_MIN && o_dec.cycles == CYC_PLD_NOF && state == ST_IDLE)
        else $error("pair load no offset");
    pair_load_of16_a: assert property (
        take_opc && i_byte == 8'hbe |=> o_dec.mode == indexed_offset16_mode
        && o_dec.len == LEN_LONG && o_dec.cycles == CYC_PLD_OF16) else $error("pair load long");
    pair_load_of8_a: assert property (
        take_opc && i_byte == 8'hce |=> o_dec.mode == indexed_offset8_mode
        && o_dec.len == LEN_SHORT && o_dec.cycles == CYC_PLD_OF8) else $error("pair load short");
    short_ea_a: assert property (
        take_opc && i_byte == 8'he6 ##1 i_byte_valid
        |=> o_ea_valid && o_ea == $past(i_sp) + {8'h00, $past(i_byte)}) else $error("short ea");
    long_ea_a: assert property (
        last_opr && mode_q == stack_offset16_mode
        |=> o_ea_valid && o_ea == $past(i_sp) + {$past(ofs[7:0]), $past(i_byte)})
        else $error("long ea");
    entry_fields_a: assert property (
        o_dec_valid |-> o_dec.illegal || (o_dec.mode != mode_none
        && o_dec.len >= LEN_MIN && o_dec.cycles != '0)) else $error("entry fields");
    illegal_flag_a: assert property (
        take_opc && i_byte inside {8'h62, 8'h65, 8'h6e, 8'hdc, 8'hed, 8'h00}
        |=> o_dec_valid && o_dec.illegal && state == ST_IDLE) else $error("illegal opcode");

    cover_decbr_c: cover property (take_opc && i_byte == 8'h6b ##1 take_opr [*2] ##1 o_ea_valid);
    cover_long_c: cover property (take_opc && i_byte[7:4] == ROW_STK16 ##[1:8] o_ea_valid);
    cover_nofs_c: cover property (take_opc && i_byte == 8'hae ##1 o_dec_valid);
    cover_bad_c:  cover property (o_dec_valid && o_dec.illegal);

endmodule

// ===== tb/psd_fetch_model.sv
// psd_fetch_model: behavioural fetch unit that plays a burst of up to eight
// instruction bytes into the decoder, one byte per valid cycle.
// assumes: shares the core clock and reset with the decoder; bench requests
// a burst with a one-cycle start pulse while the model is idle.
`timescale 1ns/10ps
module psd_fetch_model (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    // burst request from the bench
    input  wire logic        i_start,
    input  wire logic [63:0] i_bytes,
    input  wire logic [3:0]  i_count,
    input  wire logic [1:0]  i_gap,
    // byte stream to the decoder
    output logic             o_byte_valid,
    output logic [7:0]       o_byte,
    output logic             o_busy
);
    logic [63:0] shift_q;
    logic [3:0]  remain;
    logic [1:0]  idle_cnt;
    logic [1:0]  gap_q;

    // burst player; first byte sits in the top of i_bytes
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_byte_valid <= 1'b0;
            o_byte       <= 8'h00;
            shift_q      <= 64'h0;
            remain       <= 4'h0;
            idle_cnt     <= 2'h0;
            gap_q        <= 2'h0;
        end else begin
            o_byte_valid <= 1'b0;
            // an unqualified byte line keeps toggling so a stale value never looks valid
            o_byte       <= ~o_byte;
            if (remain == 4'h0) begin
                if (i_start) begin
                    shift_q  <= i_bytes;
                    remain   <= i_count;
                    gap_q    <= i_gap;
                    idle_cnt <= 2'h0;
                end
            end else if (idle_cnt != 2'h0) begin
                idle_cnt <= idle_cnt - 2'h1;  // slow fetch: idle cycles between bytes
            end else begin
                o_byte_valid <= 1'b1;
                o_byte       <= shift_q[63:56];
                shift_q      <= {shift_q[55:0], 8'h00};
                remain       <= remain - 4'h1;
                idle_cnt     <= gap_q;
            end
        end
    end

    assign o_busy = (remain != 4'h0);
endmodule

// ===== tb/tb_psd_decoder.sv
// tb_psd_decoder: self-checking bench for the second-page opcode decoder.
// assumes: decoder and fetch model share one 40 MHz clock and async reset.
`timescale 1ns/10ps
module tb_psd_decoder;
    import psd_pkg::*;

    typedef struct packed {
        logic [7:0] opc;
        psd_dec_t   dec;
    } psd_row_t;

    logic        i_clk_sys = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        start     = 1'b0;
    logic [63:0] bytes     = 64'h0;
    logic [3:0]  count     = 4'h0;
    logic [1:0]  gap       = 2'h0;
    logic [15:0] sp        = 16'hffc0;
    logic        byte_valid;
    logic [7:0]  byte_q;
    logic        busy;
    psd_dec_t    o_dec;
    logic        o_dec_valid;
    logic [15:0] o_ea;
    logic        o_ea_valid;
    logic        o_page2_active;
    psd_dec_t    seen_dec;
    logic [15:0] seen_ea;
    int          n_dec = 0;
    int          n_ea = 0;
    int          n_mismatch = 0;
    int          checked = 0;
    psd_row_t    rows [$];
    psd_op_t     rmw_tab [16] = '{op_negate_operand, op_compare_branch_equal, op_none,
        op_complement, op_shift_right, op_none, op_rotate_right, op_arith_shift_right,
        op_shift_left, op_rotate_left, op_decrement, op_decrement_branch_nonzero,
        op_increment, op_test_operand, op_none, op_clear};
    psd_op_t     reg_tab [16] = '{op_subtract, op_compare, op_subtract_carry,
        op_index_compare, op_and, op_bit_test, op_load_acc, op_store_acc, op_xor,
        op_add_carry, op_or, op_add, op_none, op_none, op_load_index, op_store_index};

    initial begin
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    psd_fetch_model fetch (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(start),
        .i_bytes(bytes), .i_count(count), .i_gap(gap), .o_byte_valid(byte_valid),
        .o_byte(byte_q), .o_busy(busy));

    psd_decoder uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_byte_valid(byte_valid),
        .i_byte(byte_q), .i_sp(sp), .o_dec(o_dec), .o_dec_valid(o_dec_valid),
        .o_ea(o_ea), .o_ea_valid(o_ea_valid), .o_page2_active(o_page2_active));

    // pulses last one cycle, so catch them at the edge that ends that cycle
    always @(posedge i_clk_sys) begin
        if (o_dec_valid === 1'b1) begin
            seen_dec <= o_dec;
            n_dec    <= n_dec + 1;
        end
        if (o_ea_valid === 1'b1) begin
            seen_ea <= o_ea;
            n_ea    <= n_ea + 1;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic void add(input logic [7:0] opc, input psd_op_t op, input psd_mode_t m,
                                input logic [2:0] len, input logic [3:0] cyc);
        if (op == op_none) begin
            rows.push_back('{opc, '{op_none, mode_none, 3'd2, 4'd0, 1'b1}});
        end else begin
            rows.push_back('{opc, '{op, m, len, cyc, 1'b0}});
        end
    endfunction

    // play a burst, then let the answer pulses land before returning
    task automatic send(input logic [63:0] b, input logic [3:0] n, input logic [1:0] g);
        int k;
        @(posedge i_clk_sys);
        bytes <= b;
        count <= n;
        gap   <= g;
        start <= 1'b1;
        @(posedge i_clk_sys);
        start <= 1'b0;
        for (k = 0; k < 60; k++) begin
            @(posedge i_clk_sys);
            if (busy === 1'b0) break;
        end
        if (k == 60) begin
            n_mismatch++;
            $display("[ERR] fetch burst expected done seen hang");
            stop_test();
        end
        repeat (4) @(posedge i_clk_sys);
    endtask

    initial begin
        int d0;
        int e0;
        int i;
        psd_row_t r;
        logic [15:0] ea;
        for (i = 0; i < 16; i++) begin
            add(8'h60 | 8'(i), rmw_tab[i], stack_offset8_mode,
                (i == 1 || i == 11) ? 3'd4 : 3'd3,
                (i == 11) ? 4'd8 : (i == 13) ? 4'd5 : 4'd6);
            add(8'hd0 | 8'(i), reg_tab[i], stack_offset16_mode, 3'd4, 4'd5);
            add(8'he0 | 8'(i), reg_tab[i], stack_offset8_mode, 3'd3, 4'd4);
        end
        add(8'hf3, op_index_pair_compare, stack_offset8_mode, 3'd3, 4'd6);
        add(8'hfe, op_index_pair_load, stack_offset8_mode, 3'd3, 4'd5);
        add(8'hff, op_index_pair_store, stack_offset8_mode, 3'd3, 4'd5);
        add(8'hae, op_index_pair_load, indexed_no_offset_mode, 3'd2, 4'd5);
        add(8'hbe, op_index_pair_load, indexed_offset16_mode, 3'd4, 4'd6);
        add(8'hce, op_index_pair_load, indexed_offset8_mode, 3'd3, 4'd5);
        // a whole unassigned row; the F row holds legal pair opcodes, so it is not used here
        foreach (reg_tab[j]) add({4'h8, 4'(j)}, op_none, mode_none, 3'd0, 4'd0);
        add(8'hf0, op_none, mode_none, 3'd0, 4'd0);
        add(8'h9e, op_none, mode_none, 3'd0, 4'd0);
        add(8'h00, op_none, mode_none, 3'd0, 4'd0);
        repeat (20) @(posedge i_clk_sys);
        check("dec in reset", 32'(o_dec), 32'h0);
        check("page2 in reset", 32'(o_page2_active), 32'h0);
        i_rst_n <= 1'b1;
        foreach (rows[j]) begin
            r  = rows[j];
            d0 = n_dec;
            e0 = n_ea;
            send({8'h9e, r.opc, 8'h55, 8'h13, 32'h0}, 4'(r.dec.len), 2'(j % 3));
            ea = (r.dec.mode == stack_offset16_mode) ? sp + 16'h5513 : sp + 16'h0055;
            check("dec count", 32'(n_dec - d0), 32'h1);
            check("dec entry", 32'(seen_dec), 32'(r.dec));
            if (r.dec.mode == stack_offset8_mode || r.dec.mode == stack_offset16_mode) begin
                check("ea count", 32'(n_ea - e0), 32'h1);
                check("ea value", 32'(seen_ea), 32'(ea));
            end else begin
                check("no ea", 32'(n_ea - e0), 32'h0);
            end
        end
        // first-page bytes in idle must not decode
        d0 = n_dec;
        send({8'ha6, 8'h60, 8'h3f, 40'h0}, 4'd3, 2'd0);
        check("idle bytes", 32'(n_dec - d0), 32'h0);
        // operand byte equal to the prefix, then back-to-back instruction
        e0 = n_ea;
        send({8'h9e, 8'he6, 8'h9e, 8'h9e, 8'h60, 8'h01, 16'h0}, 4'd6, 2'd0);
        check("prefix as operand", 32'(n_ea - e0), 32'h2);
        check("negate ea", 32'(seen_ea), 32'(sp + 16'h0001));
        // illegal opcode consumes no operand bytes
        d0 = n_dec;
        send({8'h9e, 8'h62, 8'h9e, 8'h6f, 8'h05, 24'h0}, 4'd5, 2'd1);
        check("after illegal", 32'(n_dec - d0), 32'h2);
        check("clear entry", 32'(seen_dec.op), 32'(op_clear));
        check("clear ea", 32'(seen_ea), 32'(sp + 16'h0005));
        // reset while the long offset is half fetched
        send({8'h9e, 8'hd6, 8'h11, 40'h0}, 4'd3, 2'd0);
        check("page2 mid", 32'(o_page2_active), 32'h1);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        check("page2 reset", 32'(o_page2_active), 32'h0);
        i_rst_n <= 1'b1;
        d0 = n_dec;
        send({8'h9e, 8'h6d, 8'h07, 40'h0}, 4'd3, 2'd0);
        check("test after reset", 32'(n_dec - d0), 32'h1);
        check("test entry", 32'(seen_dec), 32'({op_test_operand, stack_offset8_mode,
              3'd3, 4'd5, 1'b0}));
        check("test ea", 32'(seen_ea), 32'(sp + 16'h0007));
        stop_test();
    end
endmodule
